// *** ofs_defines.svh ***
// Offsets, field positions, reset values and timing counts of the search
`ifndef OFS_DEFINES_SVH
`define OFS_DEFINES_SVH

// Processor port address of the search status register
`define OFS_ADDR_STATUS      9'h017
`define OFS_ADDR_W           9

// Status register field positions
`define OFS_BIT_DIR          0
`define OFS_BIT_ACTIVE       1
`define OFS_BIT_TIMEOUT      2
`define OFS_BIT_FOUND        3
`define OFS_BIT_INVALID      4

// Reset values
`define OFS_STATUS_RST       8'h00
`define OFS_UPPER_ZERO       3'h0

// Clock rate and timeout intervals in microseconds
`define OFS_CLK_HZ           50000000
`define OFS_TMO_T1_US        12000
`define OFS_TMO_ESF_US       24000
`define OFS_TMO_E1_US        8000
`define OFS_TMO_FORCE_US     24000

// Cycle counts derived from the intervals (whole cycles, rounded down)
`define OFS_US2CYC(us)       ((us) * (`OFS_CLK_HZ / 1000000))
`define OFS_TMO_T1_CYC       `OFS_US2CYC(`OFS_TMO_T1_US)
`define OFS_TMO_ESF_CYC      `OFS_US2CYC(`OFS_TMO_ESF_US)
`define OFS_TMO_E1_CYC       `OFS_US2CYC(`OFS_TMO_E1_US)
`define OFS_TMO_FORCE_CYC    `OFS_US2CYC(`OFS_TMO_FORCE_US)

// Timer width, wide enough for the longest interval
`define OFS_TMR_W            21

`endif

// *** ofs_pkg.sv ***
// Types shared by the offline frame search engine
package ofs_pkg;

	// Framer mode groups that select the search timeout
	typedef enum logic [1:0] {
		OFS_MODE_T1SF,
		OFS_MODE_ESF,
		OFS_MODE_E1
	} ofs_mode_t;

	// Engine states
	typedef enum logic {
		OFS_ST_IDLE,
		OFS_ST_SEARCH
	} ofs_state_t;

endpackage

// *** ofs_timer.sv ***
// Down-counting search timeout timer
`timescale 1ns/1ps
module ofs_timer #(
	parameter int W = 21
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Control
	input  wire logic         start_i,
	input  wire logic         stop_i,
	input  wire logic [W-1:0] load_i,
	// Expiry pulse
	output logic              expire_o
);

	logic [W-1:0] cnt_q;
	logic         run_q;
	logic         last;

	assign last = run_q && (cnt_q == W'(1));

	// Count down from the loaded interval
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q    <= '0;
			run_q    <= 1'b0;
			expire_o <= 1'b0;
		end else begin
			expire_o <= last && !stop_i && !start_i;
			if (start_i) begin
				cnt_q <= load_i;
				run_q <= 1'b1;
			end else if (stop_i || last) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end

endmodule

// *** ofs_engine.sv ***
// Offline frame alignment search engine with its status register
`timescale 1ns/1ps
`include "ofs_defines.svh"
module ofs_engine #(
	parameter int unsigned TMO_T1_CYC  = `OFS_TMO_T1_CYC,
	parameter int unsigned TMO_ESF_CYC = `OFS_TMO_ESF_CYC,
	parameter int unsigned TMO_E1_CYC  = `OFS_TMO_E1_CYC,
	parameter int unsigned POS_W       = 8
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	// Processor port
	input  wire logic [`OFS_ADDR_W-1:0]  cpu_addr_i,
	input  wire logic                    cpu_rd_i,
	input  wire logic                    cpu_wr_i,
	input  wire logic [7:0]              cpu_wdata_i,
	output logic      [7:0]              cpu_rdata_o,
	// Forced reframe set strobes and held bits
	input  wire logic                    rx_force_set_i,
	input  wire logic                    tx_force_set_i,
	output logic                         rx_forced_reframe_o,
	output logic                         tx_forced_reframe_o,
	// Online framer requests and aborts
	input  wire logic                    rx_loss_of_frame_request_i,
	input  wire logic                    tx_loss_of_frame_request_i,
	input  wire logic                    rx_search_abort_i,
	input  wire logic                    tx_search_abort_i,
	input  wire ofs_pkg::ofs_mode_t      rx_mode_i,
	input  wire ofs_pkg::ofs_mode_t      tx_mode_i,
	// Candidate datapath results
	input  wire logic                    cand_one_i,
	input  wire logic                    cand_none_i,
	input  wire logic [POS_W-1:0]        cand_pos_i,
	input  wire logic                    fas_lock_i,
	input  wire logic                    mfas_lock_i,
	input  wire logic                    cas_lock_i,
	// Search control to datapath
	output logic                         search_active_o,
	output logic                         search_rx_o,
	// Results to online framers and timebases
	output logic                         rx_lof_clear_o,
	output logic                         tx_lof_clear_o,
	output logic                         rx_realign_o,
	output logic                         tx_realign_o,
	output logic      [POS_W-1:0]        realign_pos_o,
	output logic                         alignment_change_counter_inc_o,
	// E1 receive progress
	output logic                         basic_frame_progress_o,
	output logic                         multiframe_progress_o,
	output logic                         signalling_multiframe_progress_o
);

	// Reset release through two flip-flops
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	ofs_pkg::ofs_state_t state_q;
	logic               dir_q;
	logic               found_q;
	logic               timeout_q;
	logic               invalid_q;
	logic               rx_force_q;
	logic               tx_force_q;
	logic [POS_W-1:0]   rx_pos_q;
	logic               rx_pos_vld_q;

	// Request qualification and fixed-priority arbitration
	logic rx_req;
	logic tx_req;
	logic start;
	logic start_rx;
	assign rx_req   = (rx_loss_of_frame_request_i | rx_force_q)
	                  & ~rx_search_abort_i;
	assign tx_req   = (tx_loss_of_frame_request_i | tx_force_q)
	                  & ~tx_search_abort_i;
	assign start    = (state_q == ofs_pkg::OFS_ST_IDLE)
	                  && (rx_req || tx_req);
	assign start_rx = rx_req;

	// Search end conditions, abort first
	logic searching;
	logic tmr_exp;
	logic end_abort;
	logic end_found;
	logic end_none;
	logic end_tmo;
	logic finish;
	assign searching = (state_q == ofs_pkg::OFS_ST_SEARCH);
	assign end_abort = searching
	                   && (dir_q ? rx_search_abort_i : tx_search_abort_i);
	assign end_found = searching && !end_abort && cand_one_i;
	assign end_none  = searching && !end_abort && !cand_one_i
	                   && cand_none_i;
	assign end_tmo   = searching && !end_abort && !cand_one_i
	                   && !cand_none_i && tmr_exp;
	assign finish    = end_abort || end_found || end_none
	                   || end_tmo;

	// Mode dependent timeout; all intervals within the 24 ms forced bound
	ofs_pkg::ofs_mode_t        sel_mode;
	logic [`OFS_TMR_W-1:0]     tmo_load;
	assign sel_mode = start_rx ? rx_mode_i : tx_mode_i;
	assign tmo_load =
		(sel_mode == ofs_pkg::OFS_MODE_E1)  ? `OFS_TMR_W'(TMO_E1_CYC)  :
		(sel_mode == ofs_pkg::OFS_MODE_ESF) ? `OFS_TMR_W'(TMO_ESF_CYC) :
		                                      `OFS_TMR_W'(TMO_T1_CYC);

	// Timeout timer, restarted on every accepted request
	ofs_timer #(
		.W        (`OFS_TMR_W)
	) u_timer (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_q),
		.start_i  (start),
		.stop_i   (finish),
		.load_i   (tmo_load),
		.expire_o (tmr_exp)
	);

	// State: back to idle for a cycle so results show, then restart
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ofs_pkg::OFS_ST_IDLE;
		end else begin
			unique case (state_q)
				ofs_pkg::OFS_ST_IDLE: begin
					if (start) begin
						state_q <= ofs_pkg::OFS_ST_SEARCH;
					end
				end
				ofs_pkg::OFS_ST_SEARCH: begin
					if (finish) begin
						state_q <= ofs_pkg::OFS_ST_IDLE;
					end
				end
			endcase
		end
	end

	// Direction and result flags
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dir_q     <= 1'b0;
			found_q   <= 1'b0;
			timeout_q <= 1'b0;
			invalid_q <= 1'b0;
		end else if (start) begin
			dir_q     <= start_rx;
			found_q   <= 1'b0;
			timeout_q <= 1'b0;
			invalid_q <= 1'b0;
		end else if (finish) begin
			found_q   <= end_found;
			timeout_q <= end_tmo;
			invalid_q <= end_none;
		end
	end

	// Forced bits: set wins over the self-clear on start
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_force_q <= 1'b0;
			tx_force_q <= 1'b0;
		end else begin
			rx_force_q <= rx_force_set_i
			              || (rx_force_q && !(start && start_rx));
			tx_force_q <= tx_force_set_i
			              || (tx_force_q && !(start && !start_rx));
		end
	end

	// Receive alignment memory for change detection
	logic rx_moved;
	assign rx_moved = !rx_pos_vld_q || (cand_pos_i != rx_pos_q);
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_pos_q     <= '0;
			rx_pos_vld_q <= 1'b0;
		end else if (end_found && dir_q) begin
			rx_pos_q     <= cand_pos_i;
			rx_pos_vld_q <= 1'b1;
		end
	end

	// Result pulses to online framers, timebases and counter
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_lof_clear_o                 <= 1'b0;
			tx_lof_clear_o                 <= 1'b0;
			rx_realign_o                   <= 1'b0;
			tx_realign_o                   <= 1'b0;
			realign_pos_o                  <= '0;
			alignment_change_counter_inc_o <= 1'b0;
		end else begin
			rx_lof_clear_o <= end_found && dir_q;
			tx_lof_clear_o <= end_found && !dir_q;
			rx_realign_o   <= end_found && dir_q;
			tx_realign_o   <= end_found && !dir_q;
			if (end_found) begin
				realign_pos_o <= cand_pos_i;
			end
			alignment_change_counter_inc_o <=
				end_found && dir_q && rx_pos_vld_q && rx_moved;
		end
	end

	// E1 receive progress; mean reframe time rests on the datapath
	logic e1_rx;
	assign e1_rx = searching && dir_q
	               && (rx_mode_i == ofs_pkg::OFS_MODE_E1);
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			basic_frame_progress_o           <= 1'b0;
			multiframe_progress_o            <= 1'b0;
			signalling_multiframe_progress_o <= 1'b0;
		end else begin
			basic_frame_progress_o           <= e1_rx && fas_lock_i;
			multiframe_progress_o            <= e1_rx && mfas_lock_i;
			signalling_multiframe_progress_o <= e1_rx && cas_lock_i;
		end
	end

	// Status word; writes are ignored and upper bits stay zero
	logic [7:0] status;
	logic       rd_hit;
	logic       wr_unused;
	assign status  = {`OFS_UPPER_ZERO, invalid_q, found_q, timeout_q,
	                  searching, dir_q};
	assign rd_hit  = cpu_rd_i && (cpu_addr_i == `OFS_ADDR_STATUS);
	assign wr_unused = cpu_wr_i & (|cpu_wdata_i);

	// Outputs and read data straight from flip-flops
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cpu_rdata_o         <= `OFS_STATUS_RST;
			search_active_o     <= 1'b0;
			search_rx_o         <= 1'b0;
			rx_forced_reframe_o <= 1'b0;
			tx_forced_reframe_o <= 1'b0;
		end else begin
			cpu_rdata_o         <= rd_hit ? status : 8'h00;
			search_active_o     <= start || (searching && !finish);
			search_rx_o         <= start ? start_rx : dir_q;
			rx_forced_reframe_o <= rx_force_q;
			tx_forced_reframe_o <= tx_force_q;
		end
	end

	// Checks of the engine behaviour
	property p_start_active;
		@(posedge clk_i) disable iff (!rst_n_q)
		start |=> status[`OFS_BIT_ACTIVE] && !status[`OFS_BIT_TIMEOUT];
	endproperty
	a_start_active: assert property (p_start_active)
		else $error("search not active after request accepted");

	property p_rx_first;
		@(posedge clk_i) disable iff (!rst_n_q)
		(start && rx_req && tx_req) |=> status[`OFS_BIT_DIR];
	endproperty
	a_rx_first: assert property (p_rx_first)
		else $error("receive request not served first");

	property p_force_clear;
		@(posedge clk_i) disable iff (!rst_n_q)
		(start && start_rx && !rx_force_set_i) |=> !rx_force_q;
	endproperty
	a_force_clear: assert property (p_force_clear)
		else $error("forced receive bit not cleared on start");

	property p_found_lof;
		@(posedge clk_i) disable iff (!rst_n_q)
		(end_found && dir_q) |=> found_q && rx_lof_clear_o && rx_realign_o
		                         && !tx_lof_clear_o;
	endproperty
	a_found_lof: assert property (p_found_lof)
		else $error("found without loss clear and realign");

	property p_found_cause;
		@(posedge clk_i) disable iff (!rst_n_q)
		$rose(found_q) |-> $past(cand_one_i) && !invalid_q && !timeout_q;
	endproperty
	a_found_cause: assert property (p_found_cause)
		else $error("found flag without single candidate");

	property p_none;
		@(posedge clk_i) disable iff (!rst_n_q)
		end_none |=> invalid_q && !found_q ##1 (searching || invalid_q);
	endproperty
	a_none: assert property (p_none)
		else $error("no-candidate flag wrong");

	property p_tx_nocount;
		@(posedge clk_i) disable iff (!rst_n_q)
		alignment_change_counter_inc_o |-> rx_realign_o && !tx_realign_o
		                                   && realign_pos_o != $past(rx_pos_q);
	endproperty
	a_tx_nocount: assert property (p_tx_nocount)
		else $error("transmit realign counted");

	property p_restart;
		@(posedge clk_i) disable iff (!rst_n_q)
		(end_tmo && dir_q && rx_loss_of_frame_request_i && !rx_search_abort_i)
		##1 (rx_loss_of_frame_request_i && !rx_search_abort_i)
		|=> status[`OFS_BIT_ACTIVE] && status[`OFS_BIT_DIR];
	endproperty
	a_restart: assert property (p_restart)
		else $error("no new search after timeout with loss pending");

	property p_end_idle;
		@(posedge clk_i) disable iff (!rst_n_q)
		finish |=> !searching;
	endproperty
	a_end_idle: assert property (p_end_idle)
		else $error("search continues after end condition");

	property p_ro;
		@(posedge clk_i) disable iff (!rst_n_q)
		cpu_rdata_o[7:5] == 3'h0;
	endproperty
	a_ro: assert property (p_ro)
		else $error("upper status bits not zero");

	property p_wr_ignored;
		@(posedge clk_i) disable iff (!rst_n_q)
		(wr_unused && !start && !finish) |=> $stable(status);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored)
		else $error("status changed by a processor write");

	property p_e1_only;
		@(posedge clk_i) disable iff (!rst_n_q)
		basic_frame_progress_o |-> $past(rx_mode_i) == ofs_pkg::OFS_MODE_E1;
	endproperty
	a_e1_only: assert property (p_e1_only)
		else $error("progress flag outside E1 receive search");

	c_found: cover property (@(posedge clk_i) end_found);
	c_timeout: cover property (@(posedge clk_i) end_tmo);
	c_none: cover property (@(posedge clk_i) end_none);
	c_abort: cover property (@(posedge clk_i) end_abort);

endmodule

// *** ofs_cand_model.sv ***
// Behavioural candidate datapath model facing the search engine
`timescale 1ns/1ps
module ofs_cand_model (
	// Clock and engine state
	input  wire logic       clk_i,
	input  wire logic       active_i,
	// Scenario control: 0 found, 1 none, 2 many candidates
	input  wire logic [1:0] outcome_i,
	input  wire logic [7:0] delay_i,
	input  wire logic [7:0] pos_i,
	// Results into the engine
	output logic            one_o,
	output logic            none_o,
	output logic [7:0]      pos_o,
	output logic            lock_o
);
	logic [7:0] cnt_q;
	logic       due;
	// Cycles spent in the current search
	always_ff @(posedge clk_i) begin
		cnt_q <= active_i ? cnt_q + 8'h01 : 8'h00;
	end
	// One and none lines carry nothing outside a search past its delay
	assign due    = active_i && (cnt_q >= delay_i);
	assign one_o  = due && (outcome_i == 2'h0);
	assign none_o = due && (outcome_i == 2'h1);
	assign pos_o  = one_o ? pos_i : ~pos_i; // Stale position never held
	assign lock_o = active_i;
endmodule

// *** offline_frame_search_tb.sv ***
// Self-checking bench for the offline frame search engine
`timescale 1ns/1ps
`include "ofs_defines.svh"
module offline_frame_search_tb;
	localparam int T1 = 20;
	localparam int ESF = 40;
	localparam int E1 = 12;
	localparam logic [8:0] SA = `OFS_ADDR_STATUS;
	// Stimulus and observed signals
	logic               clk_i, resetn_i, rd, wr, rfs, tfs, rx_loss_of_frame_request, tx_loss_of_frame_request, rab;
	logic               tab, one, none, lock, act, dir, rclr, tclr, first;
	logic               rre, tre, inc, rfo, tfo;
	logic [8:0]         addr;
	logic [7:0]         wdata, rdata, pos, cpos, rpos, prev, v, dly;
	logic [1:0]         outc;
	logic [2:0]         prog;
	ofs_pkg::ofs_mode_t rmode, tmode;
	int                 err_count, cmp_count, seed, act_len, k;
	int                 n_rclr, n_tclr, n_inc, n_re;

	ofs_engine #(.TMO_T1_CYC(T1), .TMO_ESF_CYC(ESF), .TMO_E1_CYC(E1)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .cpu_addr_i(addr),
		.cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_wdata_i(wdata),
		.cpu_rdata_o(rdata), .rx_force_set_i(rfs), .tx_force_set_i(tfs),
		.rx_forced_reframe_o(rfo), .tx_forced_reframe_o(tfo),
		.rx_loss_of_frame_request_i(rx_loss_of_frame_request), .tx_loss_of_frame_request_i(tx_loss_of_frame_request),
		.rx_search_abort_i(rab), .tx_search_abort_i(tab),
		.rx_mode_i(rmode), .tx_mode_i(tmode), .cand_one_i(one),
		.cand_none_i(none), .cand_pos_i(cpos), .fas_lock_i(lock),
		.mfas_lock_i(lock), .cas_lock_i(lock), .search_active_o(act),
		.search_rx_o(dir), .rx_lof_clear_o(rclr), .tx_lof_clear_o(tclr),
		.rx_realign_o(rre), .tx_realign_o(tre), .realign_pos_o(rpos),
		.alignment_change_counter_inc_o(inc),
		.basic_frame_progress_o(prog[0]), .multiframe_progress_o(prog[1]),
		.signalling_multiframe_progress_o(prog[2]));

	ofs_cand_model far (.clk_i(clk_i), .active_i(act), .outcome_i(outc),
		.delay_i(dly), .pos_i(pos), .one_o(one), .none_o(none),
		.pos_o(cpos), .lock_o(lock));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Pulse counters and length of the running search
	always @(posedge clk_i) begin
		n_rclr += int'(rclr);
		n_tclr += int'(tclr);
		n_inc += int'(inc);
		n_re += int'(rre) + int'(tre);
		if (act)
			act_len++;
	end

	// Expected status byte
	function automatic logic [7:0] st(input logic a, t, f, n, d);
		return {3'h0, n, f, t, a, d};
	endfunction

	// Expected change-count pulses for one find
	function automatic int exp_inc(input logic rx, fst, input logic [7:0] p, q);
		return (rx && !fst && p != q) ? 1 : 0;
	endfunction

	// Timeout count for a mode
	function automatic int tmo(input ofs_pkg::ofs_mode_t m);
		if (m == ofs_pkg::OFS_MODE_E1)
			return E1;
		return (m == ofs_pkg::OFS_MODE_ESF) ? ESF : T1;
	endfunction

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// Register read: taken at one edge, data sampled 1 ns after that same edge
	task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd = 1'b1;
		addr = a;
		@(posedge clk_i);
		#1 d = rdata;
		@(negedge clk_i);
		rd = 1'b0;
	endtask

	task automatic wait_act(input logic lvl);
		int i;
		for (i = 0; i < 2000 && act !== lvl; i++)
			@(negedge clk_i);
		if (act !== lvl) begin
			err_count++;
			$display("BAD search_active_o expected %b seen %b", lvl, act);
			conclude();
		end
	endtask

	// One search: request, checks while running, wait for its end
	task automatic search(input logic rx, frc, input logic [1:0] oc,
		input logic [7:0] d, input logic hold);
		@(negedge clk_i);
		outc = oc;
		dly = d;
		rfs = frc & rx;
		tfs = frc & !rx;
		rx_loss_of_frame_request = rx_loss_of_frame_request | (!frc & rx);
		tx_loss_of_frame_request = tx_loss_of_frame_request | (!frc & !rx);
		@(negedge clk_i);
		rfs = 1'b0;
		tfs = 1'b0;
		wait_act(1'b1);
		act_len = 0;
		chk("direction", 8'(rx), 8'(dir));
		chk("forced held", {6'h0, frc & rx, frc & !rx},
			8'({rfo, tfo}));
		@(negedge clk_i);
		chk("progress", (rx && rmode == ofs_pkg::OFS_MODE_E1) ? 8'h07 : 8'h00,
			8'(prog));
		chk("forced bits", 8'h00, 8'({rfo, tfo}));
		rx_loss_of_frame_request = rx_loss_of_frame_request & hold;
		tx_loss_of_frame_request = tx_loss_of_frame_request & hold;
		wait_act(1'b0);
	endtask

	task automatic found_case(input logic rx, input logic [7:0] d);
		int c_r, c_t, c_i, c_e;
		c_r = n_rclr;
		c_t = n_tclr;
		c_i = n_inc;
		c_e = n_re;
		search(rx, 1'b0, 2'h0, d, 1'b0);
		rd_reg(SA, v);
		chk("status found", st(0, 0, 1, 0, rx), v);
		chk("realign position", pos, rpos);
		chk("rx loss clear", 8'(rx), 8'(n_rclr - c_r));
		chk("tx loss clear", 8'(!rx), 8'(n_tclr - c_t));
		chk("realign pulses", 8'h01, 8'(n_re - c_e));
		chk("change count", 8'(exp_inc(rx, first, pos, prev)),
			8'(n_inc - c_i));
		if (rx) begin
			first = 1'b0;
			prev = pos;
		end
	endtask

	initial begin
		seed = 98;
		{rd, wr, rfs, tfs, rx_loss_of_frame_request, tx_loss_of_frame_request, rab, tab} = 8'h00;
		{addr, wdata, pos, dly, prev, outc} = 43'h0;
		rmode = ofs_pkg::OFS_MODE_T1SF;
		tmode = ofs_pkg::OFS_MODE_T1SF;
		first = 1'b1;
		resetn_i = 1'b0;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		resetn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		// Reset value, ignored write, unmapped read
		rd_reg(SA, v);
		chk("status reset", 8'h00, v);
		@(negedge clk_i);
		wr = 1'b1;
		addr = SA;
		wdata = 8'hff;
		@(negedge clk_i);
		wr = 1'b0;
		rd_reg(SA, v);
		chk("status write", 8'h00, v);
		rd_reg(9'h018, v);
		chk("unmapped read", 8'h00, v);
		$display("Test register done");
		// Finds: four receive, then random direction; random mode and delay, random position except k == 2 repeats the previous one
		for (k = 0; k < 8; k++) begin
			rmode = ofs_pkg::ofs_mode_t'($unsigned($random(seed)) % 3);
			tmode = ofs_pkg::ofs_mode_t'($unsigned($random(seed)) % 3);
			pos = (k == 2) ? prev : 8'($random(seed));
			found_case(k < 4 || $random(seed) & 1,
				8'(2 + $unsigned($random(seed)) % 10));
		end
		$display("Test found done");
		// No candidate on transmit
		tmode = ofs_pkg::OFS_MODE_E1;
		search(1'b0, 1'b0, 2'h1, 8'h04, 1'b0);
		rd_reg(SA, v);
		chk("status none", st(0, 0, 0, 1, 0), v);
		// Timeout in each receive mode
		for (k = 0; k < 3; k++) begin
			rmode = ofs_pkg::ofs_mode_t'(k);
			search(1'b1, 1'b0, 2'h2, 8'h00, 1'b0);
			chk("timeout length", 8'h01, 8'(act_len >= tmo(rmode) + 1 &&
				act_len <= tmo(rmode) + 3));
			rd_reg(SA, v);
			chk("status timeout", st(0, 1, 0, 0, 1), v);
		end
		$display("Test timeout done");
		// Held request restarts after timeout; abort ends and blocks
		rmode = ofs_pkg::OFS_MODE_T1SF;
		search(1'b1, 1'b0, 2'h2, 8'h00, 1'b1);
		wait_act(1'b1);
		rd_reg(SA, v);
		chk("status restart", st(1, 0, 0, 0, 1), v);
		rab = 1'b1;
		wait_act(1'b0);
		repeat (4) @(negedge clk_i);
		chk("abort blocks", 8'h00, 8'(act));
		rd_reg(SA, v);
		chk("status abort", st(0, 0, 0, 0, 1), v);
		rx_loss_of_frame_request = 1'b0;
		rab = 1'b0;
		$display("Test abort done");
		// Forced transmit search times out once
		tmode = ofs_pkg::OFS_MODE_ESF;
		search(1'b0, 1'b1, 2'h2, 8'h00, 1'b0);
		chk("forced length", 8'h01,
			8'(act_len >= ESF + 1 && act_len <= ESF + 3));
		repeat (5) @(negedge clk_i);
		chk("single forced", 8'h00, 8'(act));
		rd_reg(SA, v);
		chk("status forced", st(0, 1, 0, 0, 0), v);
		$display("Test forced done");
		// Both directions pending: receive first, then transmit
		@(negedge clk_i);
		outc = 2'h0;
		dly = 8'h03;
		rx_loss_of_frame_request = 1'b1;
		tx_loss_of_frame_request = 1'b1;
		wait_act(1'b1);
		chk("receive first", 8'h01, 8'(dir));
		rx_loss_of_frame_request = 1'b0;
		wait_act(1'b0);
		wait_act(1'b1);
		chk("transmit next", 8'h00, 8'(dir));
		tx_loss_of_frame_request = 1'b0;
		wait_act(1'b0);
		$display("Test priority done");
		conclude();
	end
endmodule
